// [hw/usb_endpoint_handshake_ctrl.v]
// Endpoint handshake control for the hub and function endpoints
//
// How it works
// R1: Direction bit selects status phase direction
// R2: Last packet acknowledged moves to status phase
// R3: Status done interrupts, last-packet flag kept
// R4: Control halt request stalls IN and OUT
// R5: Firmware sets halt on unsupported or exhausted
// R6: Data endpoint halt stalls only next token
// R7: IN-loaded bit cleared only by host ACK
// R8: Isochronous IN-loaded clears once packet sent
// R9: Firmware fills FIFO only while IN-loaded clear
// R10: Last packet, nothing loaded: DATA1 status IN
// R11: Clearing IN-loaded with IN-done raises interrupt
// R12: Writing acknowledge bit one clears matching flag
// R13: Acknowledge bits act as pulses, never stored
// R14: STALL sent sets sticky stall-reported flag
// R15: OUT data held sets flag, NAKs OUT
// R16: Held OUT data kept, except early setup
// R17: OUT-data-held flag raises enabled interrupt
// R18: Endpoints 1, 2 set IN-done on completion
// R19: Reserved bits of endpoints 1, 2 read zero
// R20: Hub bitmap sent on IN, else NAK
// R21: Hub control endpoint mirrors function control endpoint
// R22: Setup received clears the other service flags
// R23: Control IN-done at read end and status
// R24: Interrupt is OR of enabled held events
`timescale 1ns/10ps
`include "usb_ep_map.vh"
module usb_endpoint_handshake_ctrl #(
	parameter ADDR_W = 13,
	parameter PORTS  = 6
) (
	// Clock and reset
	input  wire              sys_clk_i,
	input  wire              rst_i,
	// Register port
	input  wire [ADDR_W-1:0] reg_addr_i,
	input  wire [7:0]        reg_wdata_i,
	input  wire              reg_wr_i,
	input  wire              reg_rd_i,
	output reg  [7:0]        reg_rdata_o,
	// Tokens from the serial interface engine
	input  wire [2:0]        ep_sel_i,
	input  wire              tok_in_i,
	input  wire              tok_out_i,
	input  wire              tok_setup_i,
	// Transaction events from the serial interface engine
	input  wire              setup_stored_i,
	input  wire              out_stored_i,
	input  wire              in_sent_i,
	input  wire              in_acked_i,
	// Hub status change pulses
	input  wire [PORTS-1:0]  hub_change_i,
	// Handshake answer to the engine
	output reg               resp_valid_o,
	output reg  [2:0]        resp_code_o,
	output reg  [7:0]        hub_bitmap_o,
	// Interrupt to the microcontroller
	output reg               irq_o
);

	function hit;
		input [2:0] sel;
		input [2:0] code;
		begin
			hit = (sel == code);
		end
	endfunction

	function wr_at;
		input              wr;
		input [ADDR_W-1:0] addr;
		input [ADDR_W-1:0] target;
		begin
			wr_at = wr & (addr == target);
		end
	endfunction

	// Per endpoint strobes
	wire sel_hub0  = hit(ep_sel_i, `EP_HUB0);
	wire sel_func0 = hit(ep_sel_i, `EP_FUNC0);
	wire sel_func1 = hit(ep_sel_i, `EP_FUNC1);
	wire sel_func2 = hit(ep_sel_i, `EP_FUNC2);
	wire sel_hub1  = hit(ep_sel_i, `EP_HUB1);

	// Register write strobes
	wire wr_hub0  = wr_at(reg_wr_i, reg_addr_i, `HUB_EP0_CTRL_ACK_ADDR);
	wire wr_func0 = wr_at(reg_wr_i, reg_addr_i, `FUNC_EP0_CTRL_ACK_ADDR);
	wire wr_func1 = wr_at(reg_wr_i, reg_addr_i, `FUNC_EP1_CTRL_ACK_ADDR);
	wire wr_func2 = wr_at(reg_wr_i, reg_addr_i, `FUNC_EP2_CTRL_ACK_ADDR);
	wire wr_inten = wr_at(reg_wr_i, reg_addr_i, `EP_INT_ENABLE_ADDR);
	wire wr_iso   = wr_at(reg_wr_i, reg_addr_i, `EP_ISO_CFG_ADDR);

	// Software settings
	reg  [3:0] int_en_q;
	reg  [1:0] iso_q;

	// Hub interrupt endpoint bitmap
	reg  [PORTS-1:0] change_q;
	reg  [PORTS-1:0] sent_map_q;

	// Endpoint views
	wire [7:0] hub0_ctrl;
	wire [7:0] hub0_status;
	wire [7:0] func0_ctrl;
	wire [7:0] func0_status;
	wire [7:0] func1_ctrl;
	wire [7:0] func1_status;
	wire [7:0] func2_ctrl;
	wire [7:0] func2_status;
	wire [3:0] ep_event;
	wire [2:0] resp_hub0;
	wire [2:0] resp_func0;
	wire [2:0] resp_func1;
	wire [2:0] resp_func2;
	reg  [2:0] resp_d;
	reg  [7:0] rdata_d;

	// R21
	ctrl_ep_handshake u_hub_ep0 (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_hub0),
		.wdata_i   (reg_wdata_i),
		.ctrl_o    (hub0_ctrl),
		.status_o  (hub0_status),
		.event_o   (ep_event[0]),
		.tok_in_i  (tok_in_i & sel_hub0),
		.tok_out_i (tok_out_i & sel_hub0),
		.setup_i   (setup_stored_i & sel_hub0),
		.out_i     (out_stored_i & sel_hub0),
		.acked_i   (in_acked_i & sel_hub0),
		.resp_o    (resp_hub0)
	);

	ctrl_ep_handshake u_func_ep0 (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_func0),
		.wdata_i   (reg_wdata_i),
		.ctrl_o    (func0_ctrl),
		.status_o  (func0_status),
		.event_o   (ep_event[1]),
		.tok_in_i  (tok_in_i & sel_func0),
		.tok_out_i (tok_out_i & sel_func0),
		.setup_i   (setup_stored_i & sel_func0),
		.out_i     (out_stored_i & sel_func0),
		.acked_i   (in_acked_i & sel_func0),
		.resp_o    (resp_func0)
	);

	data_ep_handshake u_func_ep1 (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_func1),
		.wdata_i   (reg_wdata_i),
		.iso_i     (iso_q[0]),
		.ctrl_o    (func1_ctrl),
		.status_o  (func1_status),
		.event_o   (ep_event[2]),
		.tok_in_i  (tok_in_i & sel_func1),
		.tok_out_i (tok_out_i & sel_func1),
		.out_i     (out_stored_i & sel_func1),
		.sent_i    (in_sent_i & sel_func1),
		.acked_i   (in_acked_i & sel_func1),
		.resp_o    (resp_func1)
	);

	data_ep_handshake u_func_ep2 (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_i      (wr_func2),
		.wdata_i   (reg_wdata_i),
		.iso_i     (iso_q[1]),
		.ctrl_o    (func2_ctrl),
		.status_o  (func2_status),
		.event_o   (ep_event[3]),
		.tok_in_i  (tok_in_i & sel_func2),
		.tok_out_i (tok_out_i & sel_func2),
		.out_i     (out_stored_i & sel_func2),
		.sent_i    (in_sent_i & sel_func2),
		.acked_i   (in_acked_i & sel_func2),
		.resp_o    (resp_func2)
	);

	// Hub interrupt endpoint: the bitmap when anything changed, NAK otherwise
	wire       hub_in   = tok_in_i & sel_hub1;
	wire       hub_send = hub_in & (|change_q); // R20
	reg  [2:0] resp_hub1;

	always @*
	begin
		resp_hub1 = `RESP_NONE;
		if (hub_in)
			resp_hub1 = hub_send ? `RESP_DATA : `RESP_NAK; // R20
	end

	// A setup token is taken on every endpoint but the hub interrupt endpoint, so an early setup may overwrite held OUT data
	wire setup_take = tok_setup_i & ~sel_hub1; // R16

	// Answer selection
	always @*
	begin
		resp_d = `RESP_NONE;
		if (setup_take)
			resp_d = `RESP_ACK; // R16
		else
		begin
			case (ep_sel_i)
				`EP_HUB0:  resp_d = resp_hub0;
				`EP_FUNC0: resp_d = resp_func0;
				`EP_FUNC1: resp_d = resp_func1;
				`EP_FUNC2: resp_d = resp_func2;
				`EP_HUB1:  resp_d = resp_hub1;
				default:   resp_d = `RESP_NONE;
			endcase
		end
	end

	// Answer strobe: one cycle after every token that gets an answer
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			resp_valid_o <= 1'b0;
		else
			resp_valid_o <= (resp_d != `RESP_NONE);
	end

	// Answer code and bitmap hold until the next answer
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			resp_code_o  <= `RESP_NONE;
			hub_bitmap_o <= `EP_REG_RESET;
		end
		else
		begin
			if (resp_d != `RESP_NONE)
				resp_code_o <= resp_d;
			if (hub_send)
				hub_bitmap_o <= {{(8-PORTS){1'b0}}, change_q}; // R20
		end
	end

	// Snapshot of the bitmap offered at each IN token to the hub interrupt endpoint
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			sent_map_q <= {PORTS{1'b0}};
		else if (hub_in)
			sent_map_q <= change_q;
	end

	// Bits the host has acknowledged; a change in the same cycle sets its bit again
	wire [PORTS-1:0] taken = (in_acked_i & sel_hub1) ? sent_map_q : {PORTS{1'b0}};

	// Pending change bitmap
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			change_q <= {PORTS{1'b0}};
		else
			change_q <= hub_change_i | (change_q & ~taken); // R20
	end

	// Interrupt enables, one bit per endpoint but the hub interrupt endpoint
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			int_en_q <= 4'h0;
		else if (wr_inten)
			int_en_q <= reg_wdata_i[3:0];
	end

	// Isochronous selection for endpoints 1 and 2
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			iso_q <= 2'h0;
		else if (wr_iso)
			iso_q <= reg_wdata_i[1:0];
	end

	// Read mux; acknowledge bits read as zero since they are never stored
	always @*
	begin
		case (reg_addr_i)
			`HUB_EP0_CTRL_ACK_ADDR:  rdata_d = hub0_ctrl; // R13
			`HUB_EP0_SERVICE_ADDR:   rdata_d = hub0_status;
			`FUNC_EP0_CTRL_ACK_ADDR: rdata_d = func0_ctrl; // R13
			`FUNC_EP0_SERVICE_ADDR:  rdata_d = func0_status;
			`FUNC_EP1_CTRL_ACK_ADDR: rdata_d = func1_ctrl; // R19
			`FUNC_EP2_CTRL_ACK_ADDR: rdata_d = func2_ctrl; // R19
			`FUNC_EP1_SERVICE_ADDR:  rdata_d = func1_status;
			`FUNC_EP2_SERVICE_ADDR:  rdata_d = func2_status;
			`EP_INT_ENABLE_ADDR:     rdata_d = {4'h0, int_en_q};
			`EP_ISO_CFG_ADDR:        rdata_d = {6'h00, iso_q};
			default:                 rdata_d = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the read strobe
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			reg_rdata_o <= `EP_REG_RESET;
		else if (reg_rd_i)
			reg_rdata_o <= rdata_d;
		else
			reg_rdata_o <= 8'h00;
	end

	// Enabled held flags per endpoint; control endpoints also report status-phase completion
	wire irq_hub0  = ep_event[0] & int_en_q[0]; // R3
	wire irq_func0 = ep_event[1] & int_en_q[1]; // R17
	wire irq_func1 = ep_event[2] & int_en_q[2]; // R11
	wire irq_func2 = ep_event[3] & int_en_q[3]; // R11

	// Interrupt is registered from the held flags, so it rises one cycle after the flag and falls one cycle after the flag clears
	always @(posedge sys_clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= irq_hub0 | irq_func0 | irq_func1 | irq_func2; // R24
	end

endmodule // usb_endpoint_handshake_ctrl

// [hw/usb_ep_map.vh]
// Register offsets, field positions, codes and reset values of the endpoint handshake logic
`ifndef USB_EP_MAP_VH
`define USB_EP_MAP_VH

// Register offsets
`define HUB_EP0_CTRL_ACK_ADDR   13'h1fa7
`define HUB_EP0_SERVICE_ADDR    13'h1fa6
`define FUNC_EP0_CTRL_ACK_ADDR  13'h1fdd
`define FUNC_EP0_SERVICE_ADDR   13'h1fdc
`define FUNC_EP1_CTRL_ACK_ADDR  13'h1fdb
`define FUNC_EP2_CTRL_ACK_ADDR  13'h1fda
`define FUNC_EP1_SERVICE_ADDR   13'h1fd9
`define FUNC_EP2_SERVICE_ADDR   13'h1fd8
`define EP_INT_ENABLE_ADDR      13'h1fa0
`define EP_ISO_CFG_ADDR         13'h1fa1

// Control and acknowledge register fields
`define CA_DIR_BIT      7
`define CA_DATA_END_BIT 6
`define CA_STALL_BIT    5
`define CA_TX_RDY_BIT   4
`define CA_ACK_STALL    3
`define CA_ACK_SETUP    2
`define CA_ACK_OUT      1
`define CA_ACK_IN_DONE  0

// Reset value of every register
`define EP_REG_RESET    8'h00

// Endpoint select codes from the serial interface engine
`define EP_HUB0         3'h0
`define EP_FUNC0        3'h1
`define EP_FUNC1        3'h2
`define EP_FUNC2        3'h3
`define EP_HUB1         3'h4

// Handshake answer codes
`define RESP_NONE       3'h0
`define RESP_ACK        3'h1
`define RESP_NAK        3'h2
`define RESP_STALL      3'h3
`define RESP_DATA       3'h4
`define RESP_DATA1_ZLP  3'h5

`endif

// [hw/ctrl_ep_handshake.v]
// Control endpoint: direction, last packet, stall, IN ready and service flags
`timescale 1ns/10ps
`include "usb_ep_map.vh"
module ctrl_ep_handshake (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       rst_i,
	// Register side
	input  wire       wr_i,
	input  wire [7:0] wdata_i,
	output wire [7:0] ctrl_o,
	output wire [7:0] status_o,
	output wire       event_o,
	// Engine side
	input  wire       tok_in_i,
	input  wire       tok_out_i,
	input  wire       setup_i,
	input  wire       out_i,
	input  wire       acked_i,
	output reg  [2:0] resp_o
);

	reg dir_q, data_end_q, stall_q, tx_rdy_q, status_q;
	reg stall_sent_q, rx_setup_q, rx_out_q, in_done_q;
	wire stall_hit = (tok_in_i | tok_out_i) & stall_q;
	wire pkt_ack   = acked_i & tx_rdy_q;
	wire zlp_ack   = acked_i & ~tx_rdy_q & data_end_q & ~dir_q;

	assign ctrl_o   = {dir_q, data_end_q, stall_q, tx_rdy_q, 4'h0};
	assign status_o = {4'h0, stall_sent_q, rx_setup_q, rx_out_q, in_done_q};
	assign event_o  = rx_setup_q | rx_out_q | in_done_q;

	always @*
	begin
		resp_o = `RESP_NONE;
		if (stall_hit)
			resp_o = `RESP_STALL; // R4
		else if (tok_in_i)
		begin
			if (tx_rdy_q & ~status_q)
				resp_o = `RESP_DATA;
			else if (data_end_q & ~dir_q)
				resp_o = `RESP_DATA1_ZLP; // R10
			else
				resp_o = `RESP_NAK;
		end
		else if (tok_out_i)
			resp_o = rx_out_q ? `RESP_NAK : `RESP_ACK; // R15
	end

	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			{dir_q, data_end_q, stall_q, tx_rdy_q, status_q} <= 5'h00;
			{stall_sent_q, rx_setup_q, rx_out_q, in_done_q} <= 4'h0;
		end
		else
		begin
			if (wr_i)
			begin
				dir_q      <= wdata_i[`CA_DIR_BIT]; // R1
				data_end_q <= wdata_i[`CA_DATA_END_BIT];
				stall_q    <= wdata_i[`CA_STALL_BIT];
				tx_rdy_q   <= wdata_i[`CA_TX_RDY_BIT];
			end
			else if (pkt_ack)
				tx_rdy_q <= 1'b0; // R7
			if (setup_i)
			begin
				rx_setup_q   <= 1'b1; // R22
				rx_out_q     <= 1'b0;
				in_done_q    <= 1'b0;
				stall_sent_q <= 1'b0;
				status_q     <= 1'b0;
			end
			else
			begin
				stall_sent_q <= stall_hit | (stall_sent_q & ~(wr_i & wdata_i[`CA_ACK_STALL])); // R14
				rx_setup_q   <= rx_setup_q & ~(wr_i & wdata_i[`CA_ACK_SETUP]); // R12
				rx_out_q     <= out_i | (rx_out_q & ~(wr_i & wdata_i[`CA_ACK_OUT])); // R17
				in_done_q    <= (pkt_ack & data_end_q) | zlp_ack |
					(in_done_q & ~(wr_i & wdata_i[`CA_ACK_IN_DONE])); // R23
				if (pkt_ack & data_end_q)
					status_q <= 1'b1; // R2
				else if (zlp_ack | (out_i & status_q))
					status_q <= 1'b0; // R3
			end
		end
	end

endmodule // ctrl_ep_handshake

// [hw/data_ep_handshake.v]
// Function endpoint 1 or 2: stall, IN ready and service flags
`timescale 1ns/10ps
`include "usb_ep_map.vh"
module data_ep_handshake (
	// Clock and reset
	input  wire       sys_clk_i,
	input  wire       rst_i,
	// Register side
	input  wire       wr_i,
	input  wire [7:0] wdata_i,
	input  wire       iso_i,
	output wire [7:0] ctrl_o,
	output wire [7:0] status_o,
	output wire       event_o,
	// Engine side
	input  wire       tok_in_i,
	input  wire       tok_out_i,
	input  wire       out_i,
	input  wire       sent_i,
	input  wire       acked_i,
	output reg  [2:0] resp_o
);

	reg data_end_q, stall_q, tx_rdy_q;
	reg stall_sent_q, rx_out_q, in_done_q;
	wire stall_hit = (tok_in_i | tok_out_i) & stall_q;
	wire in_done   = tx_rdy_q & (acked_i | (sent_i & iso_i));

	assign ctrl_o   = {1'b0, data_end_q, stall_q, tx_rdy_q, 4'h0};
	assign status_o = {4'h0, stall_sent_q, 1'b0, rx_out_q, in_done_q}; // R19
	assign event_o  = rx_out_q | in_done_q;

	always @*
	begin
		resp_o = `RESP_NONE;
		if (stall_hit)
			resp_o = `RESP_STALL; // R6
		else if (tok_in_i)
			resp_o = tx_rdy_q ? `RESP_DATA : `RESP_NAK;
		else if (tok_out_i)
			resp_o = rx_out_q ? `RESP_NAK : `RESP_ACK; // R15
	end

	always @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			{data_end_q, stall_q, tx_rdy_q} <= 3'h0;
			{stall_sent_q, rx_out_q, in_done_q} <= 3'h0;
		end
		else
		begin
			if (wr_i)
			begin
				data_end_q <= wdata_i[`CA_DATA_END_BIT];
				stall_q    <= wdata_i[`CA_STALL_BIT];
				tx_rdy_q   <= wdata_i[`CA_TX_RDY_BIT];
			end
			else
			begin
				if (stall_hit)
					stall_q <= 1'b0; // R6
				if (in_done)
					tx_rdy_q <= 1'b0; // R8
			end
			stall_sent_q <= stall_hit | (stall_sent_q & ~(wr_i & wdata_i[`CA_ACK_STALL])); // R14
			rx_out_q     <= out_i | (rx_out_q & ~(wr_i & wdata_i[`CA_ACK_OUT])); // R12
			in_done_q    <= in_done | (in_done_q & ~(wr_i & wdata_i[`CA_ACK_IN_DONE])); // R18
		end
	end

endmodule // data_ep_handshake

// [testbench/ep_handshake_props.sv]
// Port-level assertions for the endpoint handshake block
`timescale 1ns/10ps
`include "usb_ep_map.vh"
module ep_handshake_props #(
	parameter ADDR_W = 13,
	parameter PORTS  = 6
) (
	// Watched ports
	input wire              sys_clk_i,
	input wire              rst_i,
	input wire [ADDR_W-1:0] reg_addr_i,
	input wire              reg_rd_i,
	input wire [7:0]        reg_rdata_o,
	input wire [2:0]        ep_sel_i,
	input wire              tok_in_i,
	input wire              tok_out_i,
	input wire              tok_setup_i,
	input wire              resp_valid_o,
	input wire [2:0]        resp_code_o,
	input wire [7:0]        hub_bitmap_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_tok_ep;
		(tok_in_i || tok_out_i) && ep_sel_i <= `EP_FUNC2;
	endsequence
	sequence s_hub_in;
		tok_in_i && ep_sel_i == `EP_HUB1 ##1 resp_valid_o;
	endsequence
	property p_tok_answer;
		s_tok_ep |=> resp_valid_o;
	endproperty
	a_tok_answer: assert property (p_tok_answer) else $error("token not answered");
	property p_setup_ack;
		tok_setup_i && ep_sel_i <= `EP_FUNC0 |=> resp_valid_o && resp_code_o == `RESP_ACK;
	endproperty
	a_setup_ack: assert property (p_setup_ack) else $error("setup not acknowledged");
	property p_quiet;
		!(tok_in_i || tok_out_i || tok_setup_i) |=> !resp_valid_o;
	endproperty
	a_quiet: assert property (p_quiet) else $error("answer without token");
	property p_hub_out;
		(tok_out_i || tok_setup_i) && ep_sel_i == `EP_HUB1 |=> !resp_valid_o;
	endproperty
	a_hub_out: assert property (p_hub_out) else $error("hub interrupt endpoint answered out");
	property p_hub_in;
		s_hub_in |-> resp_code_o == `RESP_NAK || resp_code_o == `RESP_DATA;
	endproperty
	a_hub_in: assert property (p_hub_in) else $error("hub interrupt endpoint bad code");
	property p_hold;
		!resp_valid_o |-> $stable(resp_code_o) && $stable(hub_bitmap_o);
	endproperty
	a_hold: assert property (p_hold) else $error("answer changed without token");
	property p_rdata_idle;
		!reg_rd_i |=> reg_rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
	property p_ack_zero;
		reg_rd_i && (reg_addr_i == `FUNC_EP0_CTRL_ACK_ADDR || reg_addr_i == `HUB_EP0_CTRL_ACK_ADDR)
			|=> reg_rdata_o[3:0] == 4'h0;
	endproperty
	a_ack_zero: assert property (p_ack_zero) else $error("acknowledge bit stored");
	property p_rsvd;
		reg_rd_i && (reg_addr_i == `FUNC_EP1_SERVICE_ADDR || reg_addr_i == `FUNC_EP2_SERVICE_ADDR)
			|=> reg_rdata_o[7:4] == 4'h0 && !reg_rdata_o[2];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved service bit set");
endmodule // ep_handshake_props
bind usb_endpoint_handshake_ctrl ep_handshake_props #(.ADDR_W(ADDR_W), .PORTS(PORTS)) u_ep_handshake_props (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .ep_sel_i(ep_sel_i), .tok_in_i(tok_in_i), .tok_out_i(tok_out_i),
	.tok_setup_i(tok_setup_i), .resp_valid_o(resp_valid_o), .resp_code_o(resp_code_o),
	.hub_bitmap_o(hub_bitmap_o));

// [testbench/host_engine_model.sv]
// Behavioural serial engine playing the host side of the endpoints
`timescale 1ns/10ps
module host_engine_model (
	// Clock
	input  wire       sys_clk_i,
	// Tokens and events towards the endpoints
	output reg  [2:0] ep_sel_o       = 3'h7,
	output reg        tok_in_o       = 1'b0,
	output reg        tok_out_o      = 1'b0,
	output reg        tok_setup_o    = 1'b0,
	output reg        setup_stored_o = 1'b0,
	output reg        out_stored_o   = 1'b0,
	output reg        in_sent_o      = 1'b0,
	output reg        in_acked_o     = 1'b0,
	output reg  [5:0] hub_change_o   = 6'h00
);
	// Outside a request the select shows the inverse of its last value
	task tok(input integer k, input [2:0] ep);
		begin
			@(posedge sys_clk_i);
			ep_sel_o <= ep;
			{tok_in_o, tok_out_o, tok_setup_o} <= 3'h4 >> k;
			@(posedge sys_clk_i);
			{tok_in_o, tok_out_o, tok_setup_o} <= 3'h0;
			ep_sel_o <= ~ep;
		end
	endtask
	// A gap of idle cycles models a slow engine
	task evt(input integer k, input [2:0] ep, input integer gap);
		begin
			repeat (gap) @(posedge sys_clk_i);
			@(posedge sys_clk_i);
			ep_sel_o <= ep;
			{setup_stored_o, out_stored_o, in_sent_o, in_acked_o} <= 4'h8 >> k;
			@(posedge sys_clk_i);
			{setup_stored_o, out_stored_o, in_sent_o, in_acked_o} <= 4'h0;
			ep_sel_o <= ~ep;
		end
	endtask
	task chg(input [5:0] m);
		begin
			@(posedge sys_clk_i);
			hub_change_o <= m;
			@(posedge sys_clk_i);
			hub_change_o <= 6'h00;
		end
	endtask
endmodule // host_engine_model

// [testbench/testbench.sv]
// Self-checking testbench for the endpoint handshake block
`timescale 1ns/10ps
`include "usb_ep_map.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
	// Clock, reset and register port
	reg        sys_clk_i   = 1'b0;
	reg        rst_i       = 1'b1;
	reg [12:0] reg_addr_i  = 13'h0000;
	reg [7:0]  reg_wdata_i = 8'h00;
	reg        reg_wr_i    = 1'b0;
	reg        reg_rd_i    = 1'b0;
	wire [7:0] reg_rdata_o;
	// Engine side
	wire [2:0] ep_sel_i;
	wire       tok_in_i, tok_out_i, tok_setup_i;
	wire       setup_stored_i, out_stored_i, in_sent_i, in_acked_i;
	wire [5:0] hub_change_i;
	wire       resp_valid_o, irq_o;
	wire [2:0] resp_code_o;
	wire [7:0] hub_bitmap_o;
	integer    num_errors = 0;
	integer    n_tests    = 0;
	localparam [129:0] MAP = {`HUB_EP0_CTRL_ACK_ADDR, `HUB_EP0_SERVICE_ADDR, `FUNC_EP0_CTRL_ACK_ADDR,
		`FUNC_EP0_SERVICE_ADDR, `FUNC_EP1_CTRL_ACK_ADDR, `FUNC_EP2_CTRL_ACK_ADDR, `FUNC_EP1_SERVICE_ADDR,
		`FUNC_EP2_SERVICE_ADDR, `EP_INT_ENABLE_ADDR, `EP_ISO_CFG_ADDR};

	always #5 sys_clk_i = ~sys_clk_i;

	usb_endpoint_handshake_ctrl #(.ADDR_W(13), .PORTS(6)) u_usb_endpoint_handshake_ctrl (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ep_sel_i(ep_sel_i),
		.tok_in_i(tok_in_i), .tok_out_i(tok_out_i), .tok_setup_i(tok_setup_i),
		.setup_stored_i(setup_stored_i), .out_stored_i(out_stored_i), .in_sent_i(in_sent_i),
		.in_acked_i(in_acked_i), .hub_change_i(hub_change_i), .resp_valid_o(resp_valid_o),
		.resp_code_o(resp_code_o), .hub_bitmap_o(hub_bitmap_o), .irq_o(irq_o));

	host_engine_model u_host_engine_model (
		.sys_clk_i(sys_clk_i), .ep_sel_o(ep_sel_i), .tok_in_o(tok_in_i), .tok_out_o(tok_out_i),
		.tok_setup_o(tok_setup_i), .setup_stored_o(setup_stored_i), .out_stored_o(out_stored_i),
		.in_sent_o(in_sent_i), .in_acked_o(in_acked_i), .hub_change_o(hub_change_i));

	task wr(input [12:0] a, input [7:0] d);
		begin
			@(posedge sys_clk_i);
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
			@(posedge sys_clk_i);
			reg_wr_i <= 1'b0;
		end
	endtask
	task rd(input [12:0] a, input [7:0] e);
		begin
			@(posedge sys_clk_i);
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
			@(posedge sys_clk_i);
			reg_rd_i <= 1'b0;
			#1;
			`CHK(reg_rdata_o, e)
		end
	endtask
	task tk(input integer k, input [2:0] ep, input [2:0] e);
		begin
			u_host_engine_model.tok(k, ep);
			#1;
			`CHK(resp_valid_o, 1'b1)
			`CHK(resp_code_o, e)
		end
	endtask
	task ev(input integer k, input [2:0] ep);
		u_host_engine_model.evt(k, ep, k);
	endtask
	task stop_test;
		begin
			$display("errors %0d checks %0d", num_errors, n_tests);
			if (num_errors == 0 && n_tests > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	task t_reset;
		integer i;
		begin
			for (i = 0; i < 10; i++)
				rd(MAP[i*13 +: 13], `EP_REG_RESET);
			wr(13'h1f00, 8'hff);
			rd(13'h1f00, 8'h00);
			$display("test reset done");
		end
	endtask
	task t_ctrl_read;
		begin
			wr(`FUNC_EP0_CTRL_ACK_ADDR, 8'hd0);
			tk(0, `EP_FUNC0, `RESP_DATA);
			rd(`FUNC_EP0_CTRL_ACK_ADDR, 8'hd0);
			ev(3, `EP_FUNC0);
			rd(`FUNC_EP0_CTRL_ACK_ADDR, 8'hc0);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h01);
			`CHK(irq_o, 1'b0)
			tk(0, `EP_FUNC0, `RESP_NAK);
			tk(1, `EP_FUNC0, `RESP_ACK);
			wr(`EP_INT_ENABLE_ADDR, 8'h02);
			rd(`EP_INT_ENABLE_ADDR, 8'h02);
			`CHK(irq_o, 1'b1)
			wr(`FUNC_EP0_CTRL_ACK_ADDR, 8'hc1);
			rd(`FUNC_EP0_CTRL_ACK_ADDR, 8'hc0);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h00);
			`CHK(irq_o, 1'b0)
			wr(`HUB_EP0_CTRL_ACK_ADDR, 8'h40);
			tk(0, `EP_HUB0, `RESP_DATA1_ZLP);
			ev(3, `EP_HUB0);
			rd(`HUB_EP0_SERVICE_ADDR, 8'h01);
			rd(`HUB_EP0_CTRL_ACK_ADDR, 8'h40);
			wr(`EP_INT_ENABLE_ADDR, 8'h01);
			rd(`EP_INT_ENABLE_ADDR, 8'h01);
			`CHK(irq_o, 1'b1)
			$display("test control done");
		end
	endtask
	task t_out_nak;
		begin
			wr(`EP_INT_ENABLE_ADDR, 8'h04);
			ev(1, `EP_FUNC1);
			rd(`FUNC_EP1_SERVICE_ADDR, 8'h02);
			`CHK(irq_o, 1'b1)
			tk(1, `EP_FUNC1, `RESP_NAK);
			tk(1, `EP_FUNC1, `RESP_NAK);
			wr(`FUNC_EP1_CTRL_ACK_ADDR, 8'h02);
			rd(`FUNC_EP1_SERVICE_ADDR, 8'h00);
			`CHK(irq_o, 1'b0)
			tk(1, `EP_FUNC1, `RESP_ACK);
			$display("test out done");
		end
	endtask
	task t_stall_setup;
		begin
			wr(`FUNC_EP0_CTRL_ACK_ADDR, 8'h20);
			tk(0, `EP_FUNC0, `RESP_STALL);
			tk(1, `EP_FUNC0, `RESP_STALL);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h08);
			wr(`FUNC_EP0_CTRL_ACK_ADDR, 8'h00);
			ev(1, `EP_FUNC0);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h0a);
			tk(2, `EP_FUNC0, `RESP_ACK);
			ev(0, `EP_FUNC0);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h04);
			wr(`FUNC_EP0_CTRL_ACK_ADDR, 8'h04);
			rd(`FUNC_EP0_SERVICE_ADDR, 8'h00);
			wr(`FUNC_EP2_CTRL_ACK_ADDR, 8'h20);
			tk(1, `EP_FUNC2, `RESP_STALL);
			tk(1, `EP_FUNC2, `RESP_ACK);
			rd(`FUNC_EP2_SERVICE_ADDR, 8'h08);
			wr(`FUNC_EP2_CTRL_ACK_ADDR, 8'h08);
			rd(`FUNC_EP2_SERVICE_ADDR, 8'h00);
			$display("test stall done");
		end
	endtask
	task t_in_clear;
		begin
			wr(`EP_ISO_CFG_ADDR, 8'h01);
			wr(`FUNC_EP1_CTRL_ACK_ADDR, 8'h10);
			tk(0, `EP_FUNC1, `RESP_DATA);
			ev(2, `EP_FUNC1);
			rd(`FUNC_EP1_CTRL_ACK_ADDR, 8'h00);
			`CHK(irq_o, 1'b1)
			wr(`FUNC_EP2_CTRL_ACK_ADDR, 8'h10);
			tk(0, `EP_FUNC2, `RESP_DATA);
			ev(2, `EP_FUNC2);
			rd(`FUNC_EP2_CTRL_ACK_ADDR, 8'h10);
			ev(3, `EP_FUNC2);
			rd(`FUNC_EP2_CTRL_ACK_ADDR, 8'h00);
			rd(`FUNC_EP2_SERVICE_ADDR, 8'h01);
			tk(0, `EP_FUNC2, `RESP_NAK);
			wr(`EP_ISO_CFG_ADDR, 8'h02);
			rd(`EP_ISO_CFG_ADDR, 8'h02);
			wr(`FUNC_EP2_CTRL_ACK_ADDR, 8'h10);
			tk(0, `EP_FUNC2, `RESP_DATA);
			ev(2, `EP_FUNC2);
			rd(`FUNC_EP2_CTRL_ACK_ADDR, 8'h00);
			$display("test in done");
		end
	endtask
	task t_hub_bitmap;
		begin
			tk(0, `EP_HUB1, `RESP_NAK);
			u_host_engine_model.chg(6'h04);
			tk(0, `EP_HUB1, `RESP_DATA);
			`CHK(hub_bitmap_o, 8'h04)
			ev(3, `EP_HUB1);
			tk(0, `EP_HUB1, `RESP_NAK);
			u_host_engine_model.tok(1, `EP_HUB1);
			#1;
			`CHK(resp_valid_o, 1'b0)
			`CHK(resp_code_o, `RESP_NAK)
			`CHK(hub_bitmap_o, 8'h04)
			$display("test hub done");
		end
	endtask

	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_ctrl_read;
		t_out_nak;
		t_stall_setup;
		t_in_clear;
		t_hub_bitmap;
		stop_test;
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk_i);
		num_errors++;
		stop_test;
	end
endmodule // testbench
